/* File: rtl/tbw_pkg.sv */
// Constants, types and register map of the time-base tick and wake-up block.
// Assumes an APB master with 32-bit data and byte addresses on paddr.
package tbw_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_PSC  = 8'h00;
  localparam logic [7:0] OFS_TBC  = 8'h04;
  localparam logic [7:0] OFS_FLAG = 8'h08;
  localparam logic [7:0] OFS_IEN  = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam logic [7:0] OFS_PWR  = 8'h18;
  // Field widths and positions.
  localparam int SEL_W = 2;
  localparam int PER_W = 3;
  localparam int TBC_EN_BIT = 7;
  localparam int FLG_W = 2;
  localparam int FLG_TICK = 0;
  localparam int FLG_EXT = 1;
  localparam int IEN_W = 3;
  localparam int IEN_GIE = 0;
  localparam int IEN_TICK = 1;
  localparam int IEN_EXT = 2;
  localparam int STAT_W = 3;
  localparam int STAT_TICK = 0;
  localparam int STAT_WAKE = 1;
  localparam int STAT_SVC = 2;
  // Reset values.
  localparam logic [SEL_W-1:0] RST_SEL = 2'h0;
  localparam logic [PER_W-1:0] RST_PER = 3'h0;
  localparam logic [FLG_W-1:0] RST_FLG = 2'h0;
  localparam logic [IEN_W-1:0] RST_IEN = 3'h0;
  localparam logic [STAT_W-1:0] RST_STAT = 3'h0;
  // Prescaler source codes and divider.
  localparam logic [SEL_W-1:0] SEL_DIV4 = 2'h1;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  // Shortest period exponent.
  localparam logic [3:0] PER_BASE = 4'h8;
  // Power-mode states.
  typedef enum logic [1:0] {
    PM_RUN   = 2'b01,
    PM_SLEEP = 2'b10
  } tbw_pm_type;
  // Instruction strobes from the core.
  typedef struct packed {
    logic call;
    logic sub_ret;
    logic irq_ret;
    logic halt;
  } tbw_instr_type;
  // Interrupt acknowledge to the core.
  typedef struct packed {
    logic take;
    logic ext;
    logic tick;
  } tbw_svc_type;
endpackage

/* File: rtl/tbw_prescaler.sv */
// Prescaler clock enable generator.
// Assumes sub_clk_en is a one-cycle pulse per sub-clock period.
`timescale 1ns/10ps
module tbw_prescaler (
  // Clock and reset.
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // Source selection and sub-clock.
  input  wire logic [tbw_pkg::SEL_W-1:0] src_sel,
  input  wire logic                    sub_clk_en,
  // Prescaler enable pulse.
  output logic                         psc_en
);
  logic [1:0] div_r;   // Divide-by-four phase counter.
  logic       div_en;  // One pulse every fourth core clock.

  // The divider free-runs so the quarter rate is always available.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_r <= 2'h0;
    else
      div_r <= div_r + 2'h1;
  end

  assign div_en = (div_r == tbw_pkg::DIV4_LAST);
  // Upper bit set means sub-clock, whatever the lower bit.
  assign psc_en = src_sel[1] ? sub_clk_en :
                  (src_sel == tbw_pkg::SEL_DIV4) ? div_en : 1'b1;
endmodule

/* File: rtl/tbw_tick_counter.sv */
// Time-base counter with selectable overflow interval.
// Assumes psc_en is a one-cycle pulse at the prescaler rate.
`timescale 1ns/10ps
module tbw_tick_counter #(
  parameter int CNT_W = 15  // Wide enough for the longest period.
) (
  // Clock and reset.
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // Control.
  input  wire logic                    enable,
  input  wire logic                    psc_en,
  input  wire logic [tbw_pkg::PER_W-1:0] period_sel,
  // Overflow pulse.
  output logic                         overflow
);
  logic [CNT_W-1:0] cnt_r;   // Prescaler clock count.
  logic [CNT_W-1:0] cnt_nxt; // Next count.
  logic [3:0]       shift;   // Period exponent.
  logic [CNT_W-1:0] low_mask; // Bits that form the interval.
  logic             full;    // Interval bits all ones.

  assign shift = tbw_pkg::PER_BASE + {1'b0, period_sel};
  assign low_mask = ~({CNT_W{1'b1}} << shift);
  assign full = &(cnt_r | ~low_mask);
  assign overflow = enable & psc_en & full;
  // Held clear while disabled, wraps to zero at the interval end.
  assign cnt_nxt = !enable ? '0 :
                   !psc_en ? cnt_r :
                   full ? '0 : cnt_r + 1'b1;

  // Count register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end
endmodule

/* File: rtl/tbw_top.sv */
// Time-base tick generator with request flags, wake-up and interrupt entry.
// Assumes an APB master on pclk and a core that strobes its instructions
// for one cycle and presents the program counter to be saved on pc_in.
`timescale 1ns/10ps
module tbw_top #(
  parameter int PC_W   = 11, // Program counter width.
  parameter int DEPTH  = 4,  // Return stack levels.
  parameter int N_OTH  = 3,  // Request flags of other peripherals.
  parameter int CNT_W  = 15  // Time-base counter width.
) (
  // Clock and reset.
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave.
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Clock and event inputs.
  input  wire logic                 sub_clk_en,
  input  wire logic                 ext_edge,
  input  wire logic [N_OTH-1:0]     other_req,
  // Core instruction side.
  input  wire tbw_pkg::tbw_instr_type instr,
  input  wire logic [PC_W-1:0]      pc_in,
  // Core answers.
  output tbw_pkg::tbw_svc_type      svc,
  output logic                      ret_valid,
  output logic [PC_W-1:0]           ret_pc,
  output logic                      sleeping,
  output logic                      wake,
  // Interrupt line.
  output logic                      irq
);
  localparam int SP_W = $clog2(DEPTH + 1);
  localparam int NREG = 7;
  localparam logic [SP_W-1:0] SP_FULL = SP_W'(DEPTH);

  // Decodes a byte address into one hot register select.
  function automatic logic [NREG-1:0] reg_hit(input logic [7:0] a);
    if (a == tbw_pkg::OFS_PSC)
      reg_hit = 7'h01;
    else if (a == tbw_pkg::OFS_TBC)
      reg_hit = 7'h02;
    else if (a == tbw_pkg::OFS_FLAG)
      reg_hit = 7'h04;
    else if (a == tbw_pkg::OFS_IEN)
      reg_hit = 7'h08;
    else if (a == tbw_pkg::OFS_STAT)
      reg_hit = 7'h10;
    else if (a == tbw_pkg::OFS_MASK)
      reg_hit = 7'h20;
    else if (a == tbw_pkg::OFS_PWR)
      reg_hit = 7'h40;
    else
      reg_hit = 7'h00;
  endfunction

  // Bus handshake.
  logic            setup;     // Setup phase of a transfer.
  logic            done;      // Access completes at this edge.
  logic            wr;        // Completing write.
  logic            rd;        // Completing read.
  logic [NREG-1:0] hit;       // Register select.
  logic            mapped;    // Address belongs to a register.
  logic [31:0]     rd_mux;    // Read data of the selected register.
  logic            pready_r;  // Answer in the access phase.
  logic            pslverr_r; // Unmapped address.
  logic [31:0]     prdata_r;  // Latched read data.

  // Software registers.
  logic [tbw_pkg::SEL_W-1:0]  sel_r;   // Prescaler source.
  logic                       tb_en_r; // Tick generator enable.
  logic [tbw_pkg::PER_W-1:0]  per_r;   // Tick period code.
  logic [tbw_pkg::FLG_W-1:0]  flg_r;   // Request flags.
  logic [tbw_pkg::FLG_W-1:0]  flg_nxt; // Next request flags.
  logic [tbw_pkg::IEN_W-1:0]  ien_r;   // Interrupt enables.
  logic [tbw_pkg::IEN_W-1:0]  ien_nxt; // Next interrupt enables.
  logic [tbw_pkg::STAT_W-1:0] stat_r;  // Sticky event status.
  logic [tbw_pkg::STAT_W-1:0] stat_nxt; // Next status.
  logic [tbw_pkg::STAT_W-1:0] mask_r;  // Interrupt mask.

  // Time base.
  logic psc_en;   // Prescaler clock pulse.
  logic psc_gate; // Pulse after sleep gating.
  logic tick_ovf; // Counter overflow.

  // Power mode and wake-up.
  tbw_pkg::tbw_pm_type pm_r;   // Power-mode state.
  tbw_pkg::tbw_pm_type pm_nxt; // Next state.
  logic [N_OTH+tbw_pkg::FLG_W-1:0] req_all;  // Every request flag.
  logic [N_OTH+tbw_pkg::FLG_W-1:0] req_prev; // Flags one cycle ago.
  logic                            wake_ev;  // Rising flag while asleep.

  // Interrupt entry and return stack.
  logic [PC_W-1:0] stk_mem [DEPTH]; // Saved program counters.
  logic [SP_W-1:0] sp_r;     // Filled levels.
  logic            full;     // No free level.
  logic            empty;    // Nothing saved.
  logic            busy;     // Core strobes an instruction.
  logic            svc_ok;   // Service may be granted.
  logic            take_ext; // Grant external interrupt.
  logic            take_tick; // Grant time-base interrupt.
  logic            take;     // Any grant.
  logic            push;     // Save pc_in.
  logic            pop;      // Restore a level.
  logic            svc_take_r; // Grant pulse.
  logic            svc_ext_r;  // Grant was external.
  logic            svc_tick_r; // Grant was time base.
  logic            ret_valid_r; // Restore pulse.
  logic [PC_W-1:0] ret_pc_r;   // Restored counter.
  logic            sleep_r;    // Asleep.
  logic            wake_r;     // Wake pulse.
  logic            irq_r;      // Interrupt line.

  // Bus decode; read data is captured in setup, the access ends one cycle later.
  assign setup  = psel & ~penable;
  assign done   = psel & penable & pready_r;
  assign wr     = done & pwrite;
  assign rd     = done & ~pwrite;
  assign hit    = reg_hit(paddr);
  assign mapped = |hit;

  // Unimplemented bits of every register read as zero.
  assign rd_mux = ({32{hit[0]}} & {30'h0, sel_r}) |
                  ({32{hit[1]}} & {24'h0, tb_en_r, 4'h0, per_r}) |
                  ({32{hit[2]}} & {30'h0, flg_r}) |
                  ({32{hit[3]}} & {29'h0, ien_r}) |
                  ({32{hit[4]}} & {29'h0, stat_r}) |
                  ({32{hit[5]}} & {29'h0, mask_r}) |
                  ({32{hit[6]}} & {{(31-SP_W){1'b0}}, sp_r, sleep_r});

  // Bus answer registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
    end
    else
    begin
      pready_r <= setup;
      if (setup)
      begin
        pslverr_r <= ~mapped;
        prdata_r  <= pwrite ? 32'h0 : rd_mux;
      end
    end
  end

  // Prescaler source select and time-base control registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_r   <= tbw_pkg::RST_SEL;
      tb_en_r <= 1'b0;
      per_r   <= tbw_pkg::RST_PER;
    end
    else
    begin
      if (wr && hit[0])
        sel_r <= pwdata[tbw_pkg::SEL_W-1:0];
      if (wr && hit[1])
      begin
        tb_en_r <= pwdata[tbw_pkg::TBC_EN_BIT];
        per_r   <= pwdata[tbw_pkg::PER_W-1:0];
      end
    end
  end

  // Prescaler and counter.
  tbw_prescaler u_psc (
    .pclk       (pclk),
    .presetn    (presetn),
    .src_sel    (sel_r),
    .sub_clk_en (sub_clk_en),
    .psc_en     (psc_en)
  );

  // The core clock stops in sleep; only the sub-clock keeps counting.
  assign psc_gate = psc_en & (sel_r[1] | (pm_r == tbw_pkg::PM_RUN));

  tbw_tick_counter #(
    .CNT_W (CNT_W)
  ) u_cnt (
    .pclk       (pclk),
    .presetn    (presetn),
    .enable     (tb_en_r),
    .psc_en     (psc_gate),
    .period_sel (per_r),
    .overflow   (tick_ovf)
  );

  // Request flags: hardware sets win over any clear in the same cycle.
  // A software write may set a flag ahead of sleep to mute its wake-up.
  always_comb
  begin
    flg_nxt = flg_r;
    if (wr && hit[2])
      flg_nxt = pwdata[tbw_pkg::FLG_W-1:0];
    else
    begin
      if (take_tick)
        flg_nxt[tbw_pkg::FLG_TICK] = 1'b0;
      if (take_ext)
        flg_nxt[tbw_pkg::FLG_EXT] = 1'b0;
    end
    if (tick_ovf)
      flg_nxt[tbw_pkg::FLG_TICK] = 1'b1;
    // The pin edge is seen in every power mode.
    if (ext_edge)
      flg_nxt[tbw_pkg::FLG_EXT] = 1'b1;
  end

  // Enables: interrupt return sets the global bit, a grant clears it.
  always_comb
  begin
    ien_nxt = (wr && hit[3]) ? pwdata[tbw_pkg::IEN_W-1:0] : ien_r;
    // The return and the grant override only the global bit of a write.
    if (instr.irq_ret)
      ien_nxt[tbw_pkg::IEN_GIE] = 1'b1;
    else if (take)
      ien_nxt[tbw_pkg::IEN_GIE] = 1'b0;
    // A subroutine return leaves the global bit as it stands.
  end

  // Status events are sticky; a read clears only the bits it returned,
  // so an event landing between setup and access is not lost.
  always_comb
  begin
    stat_nxt = (rd && hit[4]) ? (stat_r & ~prdata_r[tbw_pkg::STAT_W-1:0]) : stat_r;
    if (tick_ovf)
      stat_nxt[tbw_pkg::STAT_TICK] = 1'b1;
    if (wake_ev)
      stat_nxt[tbw_pkg::STAT_WAKE] = 1'b1;
    if (take)
      stat_nxt[tbw_pkg::STAT_SVC] = 1'b1;
  end

  // Flag, enable, status and mask registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flg_r  <= tbw_pkg::RST_FLG;
      ien_r  <= tbw_pkg::RST_IEN;
      stat_r <= tbw_pkg::RST_STAT;
      mask_r <= tbw_pkg::RST_STAT;
    end
    else
    begin
      flg_r  <= flg_nxt;
      ien_r  <= ien_nxt;
      stat_r <= stat_nxt;
      if (wr && hit[5])
        mask_r <= pwdata[tbw_pkg::STAT_W-1:0];
    end
  end

  // Wake-up looks at flag edges only, never at the enables.
  assign req_all = {other_req, flg_r};
  assign wake_ev = (pm_r == tbw_pkg::PM_SLEEP) &
                   (|(req_all & ~req_prev));

  // Power-mode state machine.
  always_comb
  begin
    pm_nxt = pm_r;
    case (pm_r)
      tbw_pkg::PM_RUN:
      begin
        if (instr.halt)
          pm_nxt = tbw_pkg::PM_SLEEP;
      end
      tbw_pkg::PM_SLEEP:
      begin
        if (wake_ev)
          pm_nxt = tbw_pkg::PM_RUN;
      end
      default:
        pm_nxt = tbw_pkg::PM_RUN;
    endcase
  end

  // Power-mode registers and flag history.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pm_r     <= tbw_pkg::PM_RUN;
      req_prev <= '0;
      sleep_r  <= 1'b0;
      wake_r   <= 1'b0;
    end
    else
    begin
      pm_r     <= pm_nxt;
      req_prev <= req_all;
      sleep_r  <= (pm_nxt == tbw_pkg::PM_SLEEP);
      wake_r   <= wake_ev;
    end
  end

  // Grant: running, global and own enable set, a free stack level,
  // and no instruction strobe in the same cycle, halt included.
  assign full  = (sp_r == SP_FULL);
  assign empty = (sp_r == '0);
  assign busy  = instr.call | instr.sub_ret | instr.irq_ret | instr.halt;
  assign svc_ok = (pm_r == tbw_pkg::PM_RUN) & ien_r[tbw_pkg::IEN_GIE] &
                  ~full & ~busy;
  // External request has priority over the time base.
  assign take_ext  = svc_ok & ien_r[tbw_pkg::IEN_EXT] &
                     flg_r[tbw_pkg::FLG_EXT];
  assign take_tick = svc_ok & ien_r[tbw_pkg::IEN_TICK] &
                     flg_r[tbw_pkg::FLG_TICK] & ~take_ext;
  assign take = take_ext | take_tick;

  // Only the program counter is saved; a call on a full stack is dropped.
  assign push = take | (instr.call & ~full);
  assign pop  = (instr.sub_ret | instr.irq_ret) & ~empty;

  // Stack storage needs no reset; the pointer guards every read.
  always_ff @(posedge pclk)
  begin
    if (push)
      stk_mem[sp_r[SP_W-1:0] % DEPTH] <= pc_in;
  end

  // Stack pointer and core answer registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sp_r        <= '0;
      svc_take_r  <= 1'b0;
      svc_ext_r   <= 1'b0;
      svc_tick_r  <= 1'b0;
      ret_valid_r <= 1'b0;
      ret_pc_r    <= '0;
    end
    else
    begin
      svc_take_r  <= take;
      svc_ext_r   <= take_ext;
      svc_tick_r  <= take_tick;
      ret_valid_r <= pop;
      if (push)
        sp_r <= sp_r + 1'b1;
      else if (pop)
      begin
        sp_r     <= sp_r - 1'b1;
        ret_pc_r <= stk_mem[(sp_r - 1'b1) % DEPTH];
      end
    end
  end

  // Interrupt line follows unmasked status one cycle later.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_r <= 1'b0;
    else
      irq_r <= |(stat_r & mask_r);
  end

  // Every output comes from a flip-flop.
  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign svc.take  = svc_take_r;
  assign svc.ext   = svc_ext_r;
  assign svc.tick  = svc_tick_r;
  assign ret_valid = ret_valid_r;
  assign ret_pc    = ret_pc_r;
  assign sleeping  = sleep_r;
  assign wake      = wake_r;
  assign irq       = irq_r;
endmodule

/* File: verif/tbw_monitor.sv */
// Port-level checks of the tick and wake-up block.
// Assumes it is bound to tbw_top, one clock, active-low reset.
`timescale 1ns/10ps
module tbw_monitor #(
  parameter int N_OTH = 3  // Other request lines.
) (
  // Clock and reset.
  input wire logic                   pclk,
  input wire logic                   presetn,
  // Register bus.
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [7:0]             paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // Core side.
  input wire logic [N_OTH-1:0]       other_req,
  input wire tbw_pkg::tbw_instr_type instr,
  input wire tbw_pkg::tbw_svc_type   svc,
  input wire logic                   ret_valid,
  input wire logic                   sleeping,
  input wire logic                   wake,
  input wire logic                   irq
);
  // Every check runs on the bus clock and rests during reset.
  default clocking mon_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_rdy_access: assert property (psel && !penable |=> pready)
    else $error("no ready in first access cycle");
  a_rdy_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_unmapped: assert property (pready && paddr > 8'h18 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (pready && paddr <= 8'h18 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  a_psc_unused: assert property (pready && !pwrite && paddr == 8'h00 |-> prdata[31:2] == 30'h0)
    else $error("source select unused bits set");
  a_tbc_unused: assert property (pready && !pwrite && paddr == 8'h04 |-> prdata[6:3] == 4'h0)
    else $error("control unused bits set");
  a_svc_single: assert property (svc.take |-> (svc.tick ^ svc.ext) ##1 !svc.take)
    else $error("bad service pulse");
  a_halt_sleep: assert property (instr.halt && !sleeping |=> sleeping)
    else $error("halt did not sleep");
  a_wake_exit: assert property (wake |-> !sleeping && $past(sleeping))
    else $error("wake without leaving sleep");
  a_wake_other: assert property (sleeping && (other_req & ~$past(other_req)) != '0 |-> ##[1:2] wake)
    else $error("rising request did not wake");
  a_ret_cause: assert property (ret_valid |-> $past(instr.sub_ret || instr.irq_ret))
    else $error("return data without return");
  a_irq_masked: assert property (pready && pwrite && paddr == 8'h14 && pwdata[2:0] == 3'h0 |=> ##1 !irq)
    else $error("masked interrupt still high");
endmodule

/* File: verif/tbw_core_model.sv */
// Behavioural core: issues instruction strobes, records answers.
// Assumes strobes are one cycle, launched just after a rising edge.
`timescale 1ns/10ps
module tbw_core_model #(
  parameter int PC_W = 11  // Program counter width.
) (
  // Clock.
  input wire logic                   pclk,
  // Answers from the block.
  input wire tbw_pkg::tbw_svc_type   svc,
  input wire logic                   ret_valid,
  input wire logic [PC_W-1:0]        ret_pc,
  input wire logic                   wake,
  // Requests to the block.
  output tbw_pkg::tbw_instr_type     instr,
  output logic [PC_W-1:0]            pc_in
);
  int                   n_take;    // Services seen.
  int                   n_wake;    // Wake pulses seen.
  tbw_pkg::tbw_svc_type last_svc;  // Last service pulse.
  logic [PC_W-1:0]      got_pc;    // Last restored counter.
  initial
  begin
    instr = '0;
    pc_in = '0;
    n_take = 0;
    n_wake = 0;
    last_svc = '0;
    got_pc = '0;
  end
  // Record answers; only the counter comes back from the stack.
  always @(posedge pclk)
  begin
    if (svc.take)
    begin
      n_take <= n_take + 1;
      last_svc <= svc;
    end
    if (ret_valid)
      got_pc <= ret_pc;
    if (wake)
      n_wake <= n_wake + 1;
  end
  // One-cycle strobe with the counter to be saved.
  task automatic run(input tbw_pkg::tbw_instr_type kind, input logic [PC_W-1:0] pc);
    @(posedge pclk);
    instr <= kind;
    pc_in <= pc;
    @(posedge pclk);
    instr <= '0;
  endtask
endmodule

/* File: verif/tb_tbw_top.sv */
// Self-checking bench for the tick and wake-up block.
// Assumes the core model and the bound port monitor.
`timescale 1ns/10ps
`define CHK(g, e) \
  begin \
    n_checks++; \
    if ((g) !== (e)) \
    begin \
      err_total++; \
      $display("[ERR] %0t got %0h expected %0h", $time, (g), (e)); \
    end \
  end
module tb_tbw_top;
  logic                   pclk;
  logic                   presetn;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [7:0]             paddr;
  logic [31:0]            pwdata;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   sub_clk_en;
  logic [2:0]             sub_cnt;
  logic                   ext_edge;
  logic [2:0]             other_req;
  tbw_pkg::tbw_instr_type instr;
  logic [10:0]            pc_in;
  tbw_pkg::tbw_svc_type   svc;
  logic                   ret_valid;
  logic [10:0]            ret_pc;
  logic                   sleeping;
  logic                   wake;
  logic                   irq;
  int                     err_total;
  int                     n_checks;
  int                     k;
  int                     per;
  logic [31:0]            rd_d;
  logic                   rd_e;
  logic [1:0]             sel;
  logic [2:0]             code;
  localparam logic [3:0] I_CALL = 4'h8;
  localparam logic [3:0] I_SRET = 4'h4;
  localparam logic [3:0] I_IRET = 4'h2;
  localparam logic [3:0] I_HALT = 4'h1;
  tbw_top u_tbw_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sub_clk_en, .ext_edge, .other_req, .instr, .pc_in, .svc, .ret_valid, .ret_pc,
    .sleeping, .wake, .irq);
  tbw_core_model u_tbw_core_model (.pclk, .svc, .ret_valid, .ret_pc, .wake, .instr, .pc_in);
  // Clock of 100 ns.
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Sub-clock pulse every eighth cycle.
  always @(posedge pclk)
  begin
    if (!presetn)
    begin
      sub_cnt <= 3'h0;
      sub_clk_en <= 1'b0;
    end
    else
    begin
      sub_cnt <= sub_cnt + 3'h1;
      sub_clk_en <= (sub_cnt == 3'h7);
    end
  end
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // One bus transfer; waits for ready under a bound.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    rd_d = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16)
    begin
      err_total++;
      $display("[ERR] %0t bus timeout", $time);
      final_report();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd_d, e)
  endtask
  task automatic ext_pulse();
    @(posedge pclk);
    ext_edge <= 1'b1;
    @(posedge pclk);
    ext_edge <= 1'b0;
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, ext_edge, other_req} = '0;
    {err_total, n_checks} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(tbw_pkg::OFS_TBC, 32'h0);
    wr(tbw_pkg::OFS_PSC, 32'hFFFFFFFF);
    rdchk(tbw_pkg::OFS_PSC, 32'h3);
    wr(tbw_pkg::OFS_TBC, 32'hFFFFFFFF);
    rdchk(tbw_pkg::OFS_TBC, 32'h87);
    apb(1'b0, 8'h40, 32'h0);
    `CHK({rd_e, rd_d}, 33'h100000000)
    wr(tbw_pkg::OFS_TBC, 32'h0);
    // Every period code on the core clock, then each other source.
    for (k = 0; k < 11; k++)
    begin
      sel = (k < 8) ? 2'h0 : 2'(k - 7);
      code = (k < 8) ? 3'(k) : 3'h0;
      per = (1 << (8 + code)) * ((sel == 2'h0) ? 1 : ((sel == 2'h1) ? 4 : 8));
      wr(tbw_pkg::OFS_MASK, 32'(k != 1));
      wr(tbw_pkg::OFS_PSC, {30'h0, sel});
      wr(tbw_pkg::OFS_TBC, {24'h0, 1'b1, 4'h0, code});
      repeat (per - 16) @(posedge pclk);
      rdchk(tbw_pkg::OFS_FLAG, 32'h0);
      repeat (20) @(posedge pclk);
      rdchk(tbw_pkg::OFS_FLAG, 32'h1);
      wr(tbw_pkg::OFS_TBC, 32'h0);
      `CHK(irq, 1'(k != 1))
      rdchk(tbw_pkg::OFS_STAT, 32'h1);
      repeat (2) @(posedge pclk);
      `CHK(irq, 1'b0)
      wr(tbw_pkg::OFS_FLAG, 32'h0);
    end
    repeat (300) @(posedge pclk);
    rdchk(tbw_pkg::OFS_FLAG, 32'h0);
    // Service needs both enables; the flag waits meanwhile.
    u_tbw_core_model.run(4'h0, 11'h123);
    wr(tbw_pkg::OFS_FLAG, 32'h1);
    wr(tbw_pkg::OFS_IEN, 32'h2);
    repeat (4) @(posedge pclk);
    `CHK(u_tbw_core_model.n_take, 0)
    rdchk(tbw_pkg::OFS_FLAG, 32'h1);
    wr(tbw_pkg::OFS_IEN, 32'h3);
    repeat (3) @(posedge pclk);
    `CHK(u_tbw_core_model.last_svc, 3'h5)
    rdchk(tbw_pkg::OFS_FLAG, 32'h0);
    rdchk(tbw_pkg::OFS_IEN, 32'h2);
    rdchk(tbw_pkg::OFS_STAT, 32'h4);
    u_tbw_core_model.run(I_IRET, 11'h0);
    repeat (2) @(posedge pclk);
    `CHK(u_tbw_core_model.got_pc, 11'h123)
    rdchk(tbw_pkg::OFS_IEN, 32'h3);
    wr(tbw_pkg::OFS_IEN, 32'h2);
    u_tbw_core_model.run(I_CALL, 11'h055);
    u_tbw_core_model.run(I_SRET, 11'h0);
    repeat (2) @(posedge pclk);
    `CHK(u_tbw_core_model.got_pc, 11'h055)
    rdchk(tbw_pkg::OFS_IEN, 32'h2);
    // A full stack holds the grant off until one level is popped.
    for (k = 1; k <= 4; k++)
      u_tbw_core_model.run(I_CALL, 11'(k));
    rdchk(tbw_pkg::OFS_PWR, 32'h8);
    wr(tbw_pkg::OFS_FLAG, 32'h1);
    wr(tbw_pkg::OFS_IEN, 32'h3);
    repeat (4) @(posedge pclk);
    `CHK(u_tbw_core_model.n_take, 1)
    u_tbw_core_model.run(I_SRET, 11'h0);
    repeat (4) @(posedge pclk);
    `CHK(u_tbw_core_model.got_pc, 11'h004)
    `CHK(u_tbw_core_model.n_take, 2)
    // Second reset in mid-run clears enables and stack.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(tbw_pkg::OFS_PWR, 32'h0);
    // Wake-up with every enable cleared.
    u_tbw_core_model.run(I_HALT, 11'h0);
    repeat (2) @(posedge pclk);
    `CHK(sleeping, 1'b1)
    other_req <= 3'h1;
    repeat (5) @(posedge pclk);
    `CHK(u_tbw_core_model.n_wake, 1)
    other_req <= 3'h0;
    u_tbw_core_model.run(I_HALT, 11'h0);
    ext_pulse();
    repeat (5) @(posedge pclk);
    `CHK(u_tbw_core_model.n_wake, 2)
    rdchk(tbw_pkg::OFS_FLAG, 32'h2);
    rdchk(tbw_pkg::OFS_STAT, 32'h2);
    // Both flags pending: the external one is granted first.
    wr(tbw_pkg::OFS_FLAG, 32'h3);
    wr(tbw_pkg::OFS_IEN, 32'h7);
    repeat (3) @(posedge pclk);
    `CHK(u_tbw_core_model.last_svc, 3'h6)
    rdchk(tbw_pkg::OFS_FLAG, 32'h1);
    // A flag set high by software ahead of sleep cannot wake the core.
    wr(tbw_pkg::OFS_FLAG, 32'h3);
    u_tbw_core_model.run(I_HALT, 11'h0);
    ext_pulse();
    repeat (5) @(posedge pclk);
    `CHK({sleeping, 4'(u_tbw_core_model.n_wake)}, 5'h12)
    final_report();
  end
endmodule
bind tbw_top tbw_monitor #(.N_OTH(N_OTH)) u_tbw_monitor (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .other_req, .instr, .svc, .ret_valid, .sleeping,
  .wake, .irq);
